// ==== verilog/adc_port_map.vh ====
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH
// --------------------------------------------------------------
// address and codes
// --------------------------------------------------------------
`define ADDR_FIXED 3'h3
`define HS_CODE_TOP 5'h01
`define BYTE_BITS 4'h8
`define ACK_BIT 4'h8
`define TRACK_CYCLES 2'h2
// --------------------------------------------------------------
// converter timing
// --------------------------------------------------------------
`define CONV_TIME_NS 3500
`define CLK_PERIOD_NS 4
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RES_WIDTH 16
`endif

// ==== verilog/pair_buffer.v ====
`timescale 1ns/1ps
module pair_buffer #(
  parameter WIDTH = 16
)
(
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire flush,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:1];
  reg rd;
  reg wr;
  reg [1:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = store[rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk)
  begin
    if (!resetn || (ce && flush))
    begin
      rd <= 1'b0;
      wr <= 1'b0;
      count <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        store[wr] <= in_data;
        wr <= ~wr;
      end
      if (pop)
        rd <= ~rd;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule

// ==== verilog/adc_i2c_slave.v ====
`timescale 1ns/1ps
`include "adc_port_map.vh"
// Overview of operation
// - each byte is eight data bits then one acknowledge bit
// - sda changes only while scl low; change while high is control
// - sda and scl released when idle
// - start and stop conditions are detected
// - stop releases bus and returns fast mode; repeated start keeps mode
// - acknowledge drives sda low through ninth clock high phase
// - not-acknowledge leaves sda released on ninth clock
// - address is 011 plus four strap bits plus read/write bit
// - idle watches start plus own address; match starts acquisition
// - matching address is acknowledged, then conversion starts
// - internal reference: bit 1 normal, bit 0 requests reference off
// - after reset bus timing is fast/standard mode
// - master code 0000 1xxx gets not-acknowledge, then high speed
// - scl held low during conversion until result ready
// - result msb first: bits 13..6, then 5..0 and two sub bits
// - conversions repeat while master acknowledges; nack frees bus
// - reset places converter in shutdown
// - interface always on; converter powers per conversion
// - internal reference stays on unless shutdown requested
// - requested shutdown occurs on master nack during readout
// - reference wakes on ninth falling scl of valid address
// - track input two scl cycles before conversion, then hold
module adc_i2c_slave #(
  parameter CONV_CYCLES = `CONV_CYCLES
)
(
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire ce,
  // two-wire link
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  // address straps
  input wire addr_select_pin_0,
  input wire addr_select_pin_1,
  input wire addr_select_pin_2,
  input wire addr_select_pin_3,
  // converter side
  input wire external_reference,
  input wire [13:0] conv_result,
  input wire [1:0] conv_sub_bits,
  output reg track,
  output reg converter_on,
  output reg reference_on,
  output reg high_speed,
  output reg conv_start
);
  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  reg [1:0] scl_s;
  reg [1:0] sda_s;
  reg [3:0] strap_s1;
  reg [3:0] strap;
  reg ext_ref_s1;
  reg ext_ref;
  reg scl_d;
  reg sda_d;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      strap_s1 <= 4'h0;
      strap <= 4'h0;
      ext_ref_s1 <= 1'b0;
      ext_ref <= 1'b0;
    end
    else if (ce)
    begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
      strap_s1 <= {addr_select_pin_3, addr_select_pin_2,
        addr_select_pin_1, addr_select_pin_0};
      strap <= strap_s1;
      ext_ref_s1 <= external_reference;
      ext_ref <= ext_ref_s1;
    end
  end
  assign scl_rise = scl_s[1] && !scl_d;
  assign scl_fall = !scl_s[1] && scl_d;
  assign start_cond = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign stop_cond = scl_s[1] && scl_d && !sda_d && sda_s[1];
  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  localparam IDLE = 3'h0;
  localparam ADDR = 3'h1;
  localparam AACK = 3'h2;
  localparam CONV = 3'h3;
  localparam SEND = 3'h4;
  localparam MACK = 3'h5;
  localparam HOLD = 3'h6;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [15:0] txreg;
  reg byte_sel;
  reg ref_off_req;
  reg [15:0] conv_cnt;
  reg [1:0] scl_seen;
  wire addr_match;
  wire hs_code;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`RES_WIDTH-1:0] buf_out_data;
  reg buf_push;
  reg buf_pop;
  reg buf_flush;
  assign addr_match = (shreg[7:5] == `ADDR_FIXED) &&
    (shreg[4:1] == strap);
  assign hs_code = (shreg[7:3] == `HS_CODE_TOP);
  // result pair travels through a two-entry buffer
  pair_buffer #(.WIDTH(`RES_WIDTH)) result_buf (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .flush(buf_flush),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data({conv_result, conv_sub_bits}),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 16'h0000;
      byte_sel <= 1'b0;
      ref_off_req <= 1'b0;
      conv_cnt <= 16'h0000;
      scl_seen <= 2'h0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_out <= 1'b0;
      scl_oe_n <= 1'b1;
      track <= 1'b0;
      converter_on <= 1'b0;
      reference_on <= 1'b0;
      high_speed <= 1'b0;
      conv_start <= 1'b0;
      buf_push <= 1'b0;
      buf_pop <= 1'b0;
      buf_flush <= 1'b0;
    end
    else if (ce)
    begin
      conv_start <= 1'b0;
      buf_push <= 1'b0;
      buf_pop <= 1'b0;
      buf_flush <= 1'b0;
      if (stop_cond)
      begin
        state <= IDLE;
        sda_oe_n <= 1'b1;
        scl_oe_n <= 1'b1;
        high_speed <= 1'b0;
        converter_on <= 1'b0;
        track <= 1'b0;
        buf_flush <= 1'b1;
      end
      else if (start_cond)
      begin
        // repeated start keeps the timing mode
        state <= ADDR;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
        scl_oe_n <= 1'b1;
        buf_flush <= 1'b1;
      end
      else
      begin
        case (state)
          IDLE:
          begin
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
          end
          ADDR:
          begin
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_s[1]};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == `BYTE_BITS)
            begin
              bitcnt <= 4'h0;
              if (addr_match)
              begin
                sda_oe_n <= 1'b0;
                state <= AACK;
                track <= 1'b1;
                converter_on <= 1'b1;
                scl_seen <= 2'h0;
                if (!ext_ref)
                  ref_off_req <= !shreg[0];
              end
              else if (hs_code)
              begin
                high_speed <= 1'b1;
                state <= IDLE;
              end
              else
                state <= IDLE;
            end
          end
          AACK:
          begin
            if (scl_fall)
            begin
              sda_oe_n <= 1'b1;
              if (scl_seen == 2'h0 && !ext_ref)
                reference_on <= 1'b1;
              scl_seen <= scl_seen + 2'h1;
              // two scl cycles of tracking then conversion
              if (scl_seen == `TRACK_CYCLES)
              begin
                track <= 1'b0;
                scl_oe_n <= 1'b0;
                conv_start <= 1'b1;
                conv_cnt <= 16'h0000;
                state <= CONV;
              end
            end
          end
          CONV:
          begin
            if (conv_cnt == CONV_CYCLES[15:0] - 16'h0001)
            begin
              if (buf_in_ready)
              begin
                buf_push <= 1'b1;
                converter_on <= 1'b0;
                state <= HOLD;
              end
            end
            else
              conv_cnt <= conv_cnt + 16'h0001;
          end
          HOLD:
          begin
            // one cycle for the buffer to show the word
            if (buf_out_valid)
            begin
              txreg <= buf_out_data;
              buf_pop <= 1'b1;
              byte_sel <= 1'b0;
              bitcnt <= 4'h0;
              sda_oe_n <= buf_out_data[15];
              state <= SEND;
            end
          end
          SEND:
          begin
            // data settles a cycle before scl is let go
            scl_oe_n <= 1'b1;
            if (scl_fall)
            begin
              if (bitcnt == `BYTE_BITS - 4'h1)
              begin
                sda_oe_n <= 1'b1;
                bitcnt <= 4'h0;
                state <= MACK;
              end
              else
              begin
                txreg <= {txreg[14:0], 1'b0};
                sda_oe_n <= txreg[14];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          MACK:
          begin
            if (scl_rise)
            begin
              if (sda_s[1])
              begin
                state <= IDLE;
                if (ref_off_req && !ext_ref)
                  reference_on <= 1'b0;
              end
              else if (byte_sel)
              begin
                // same two tracking clocks as after an address
                track <= 1'b1;
                converter_on <= 1'b1;
                scl_seen <= 2'h0;
                state <= AACK;
              end
            end
            else if (scl_fall && !byte_sel)
            begin
              // low byte's first bit goes out on the ack clock's fall
              byte_sel <= 1'b1;
              txreg <= {txreg[14:0], 1'b0};
              sda_oe_n <= txreg[14];
              state <= SEND;
            end
          end
          default:
            state <= IDLE;
        endcase
      end
    end
  end
endmodule

// ==== testbench/adc_i2c_slave_assertions.sv ====
`timescale 1ns/1ps
module adc_i2c_slave_assertions #(
  parameter CONV_CYCLES = 20
)
(
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire ce,
  // link and converter
  input wire scl_in,
  input wire scl_oe_n,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire external_reference,
  input wire track,
  input wire converter_on,
  input wire reference_on,
  input wire high_speed,
  input wire conv_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  localparam int MAXS = CONV_CYCLES + 8;
  a_ack_drives_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("sda driven high");
  a_stretch_in_conv: assert property ($fell(scl_oe_n) |-> converter_on)
    else $error("stretch outside conversion");
  a_stretch_bounded: assert property ($fell(scl_oe_n) |-> ##[1:MAXS] scl_oe_n)
    else $error("stretch too long");
  a_stretch_held: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*8])
    else $error("stretch too short");
  a_sda_moves_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved while scl high");
  a_pulse_single: assert property (conv_start |=> !conv_start)
    else $error("start pulse too wide");
  a_start_powers: assert property (conv_start |-> ##[0:2] converter_on)
    else $error("converter not powered");
  a_ref_in_conv: assert property (conv_start && !external_reference |-> reference_on)
    else $error("reference off at conversion");
  a_hs_stop_only: assert property ($fell(high_speed) && $past(resetn) |-> scl_in && sda_in)
    else $error("high speed left without stop");
  a_track_then_conv: assert property ($fell(track) && $past(resetn) |-> ##[0:3] conv_start)
    else $error("no conversion after tracking");
  a_reset_idle: assert property (disable iff (1'h0) !resetn && ce |=> sda_oe_n && scl_oe_n && !converter_on && !reference_on)
    else $error("not idle in reset");
endmodule
bind adc_i2c_slave adc_i2c_slave_assertions #(.CONV_CYCLES(CONV_CYCLES)) watch (
  .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl_in),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .external_reference(external_reference),
  .track(track), .converter_on(converter_on),
  .reference_on(reference_on), .high_speed(high_speed),
  .conv_start(conv_start));

// ==== testbench/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model
(
  // clock
  input wire clk,
  // pulled-up lines, pull-low requests
  input wire scl,
  input wire sda,
  output reg scl_low,
  output reg sda_low
);
  integer n;
  reg stuck;
  initial
  begin
    stuck = 1'h0;
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  // quarter of the 64 ns link period
  task q;
  begin
    repeat (4) @(posedge clk);
  end
  endtask
  // bounded wait, the device may stretch
  task rise;
  begin
    scl_low <= 1'h0;
    n = 0;
    while (scl !== 1'h1 && n < 5000)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if (n >= 5000)
      stuck = 1'h1;
  end
  endtask
  task start;
  begin
    sda_low <= 1'h0;
    q;
    rise;
    q;
    sda_low <= 1'h1;
    q;
    scl_low <= 1'h1;
    q;
  end
  endtask
  task xfer(input integer nb, input [8:0] tx, output [8:0] rx);
    integer i;
  begin
    for (i = nb - 1; i >= 0; i = i - 1)
    begin
      sda_low <= ~tx[i];
      q;
      rise;
      q;
      rx[i] = sda;
      q;
      scl_low <= 1'h1;
      q;
    end
  end
  endtask
  task stop;
  begin
    sda_low <= 1'h1;
    q;
    rise;
    q;
    sda_low <= 1'h0;
    q;
  end
  endtask
endmodule

// ==== testbench/adc_i2c_slave_tb.sv ====
`timescale 1ns/1ps
module adc_i2c_slave_tb;
  reg clk;
  reg resetn;
  reg ce;
  reg [3:0] straps;
  reg ext_ref;
  reg [13:0] result;
  reg [1:0] sub;
  wire scl_out, scl_oe_n, sda_out, sda_oe_n, scl_low, sda_low;
  wire track, converter_on, reference_on, high_speed, conv_start;
  integer failures;
  integer tests_run;
  reg [8:0] rx;
  reg [15:0] w;
  // ----------------------------------
  // open-drain lines with pull-ups
  // ----------------------------------
  wire scl = !(scl_low || (!scl_oe_n && !scl_out));
  wire sda = !(sda_low || (!sda_oe_n && !sda_out));
  adc_i2c_slave #(.CONV_CYCLES(20)) dut (
    .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_pin_0(straps[0]),
    .addr_select_pin_1(straps[1]), .addr_select_pin_2(straps[2]),
    .addr_select_pin_3(straps[3]), .external_reference(ext_ref),
    .conv_result(result), .conv_sub_bits(sub), .track(track),
    .converter_on(converter_on), .reference_on(reference_on),
    .high_speed(high_speed), .conv_start(conv_start));
  i2c_master_model m (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  task chk(input [79:0] name, input [15:0] e, input [15:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("Error %0s expected %h seen %h", name, e, g);
    end
  end
  endtask
  task addr(input [7:0] a);
  begin
    m.start;
    m.xfer(9, {a, 1'h1}, rx);
  end
  endtask
  // two tracking clocks, then the stretched word
  task word(input last);
  begin
    m.xfer(2, 9'h1FF, rx);
    m.xfer(9, 9'h1FE, rx);
    w[15:8] = rx[8:1];
    m.xfer(9, {8'hFF, last}, rx);
    w[7:0] = rx[8:1];
    chk("stretch", 16'h0, m.stuck);
  end
  endtask
  task t_reset;
  begin
    chk("oe_n", 16'h3, {sda_oe_n, scl_oe_n});
    chk("pwr", 16'h0, {converter_on, reference_on, high_speed});
    $display("reset test done");
  end
  endtask
  task t_read;
  begin
    addr(8'h75);
    chk("ack", 16'h0, rx[0]);
    chk("ref", 16'h1, reference_on);
    chk("track", 16'h1, track);
    word(1'h0);
    chk("word1", {result, sub}, w);
    word(1'h1);
    chk("word2", {result, sub}, w);
    m.stop;
    chk("ref", 16'h1, reference_on);
    chk("conv", 16'h0, converter_on);
    $display("read test done");
  end
  endtask
  task t_miss;
  begin
    addr(8'h65);
    chk("nack", 16'h1, rx[0]);
    m.xfer(9, 9'h1FF, rx);
    chk("ignored", 16'h1FF, rx);
    m.stop;
    $display("miss test done");
  end
  endtask
  task t_hs;
  begin
    m.start;
    m.xfer(9, 9'h013, rx);
    chk("hs_nack", 16'h1, rx[0]);
    chk("hs", 16'h1, high_speed);
    addr(8'h75);
    chk("hs_rs", 16'h1, high_speed);
    word(1'h1);
    chk("hs_word", {result, sub}, w);
    m.stop;
    chk("fs", 16'h0, high_speed);
    $display("high speed test done");
  end
  endtask
  task t_ref_off;
  begin
    @(posedge clk);
    result <= 14'h1555;
    sub <= 2'h2;
    addr(8'h74);
    chk("ack0", 16'h0, rx[0]);
    chk("ref_kept", 16'h1, reference_on);
    word(1'h1);
    chk("word0", 16'h5556, w);
    m.stop;
    chk("ref_off", 16'h0, reference_on);
    addr(8'h75);
    chk("ref_wake", 16'h1, reference_on);
    word(1'h1);
    m.stop;
    $display("reference test done");
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // hang guard, far beyond the expected run
  initial
  begin
    #200000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial
  begin
    resetn = 1'h0;
    ce = 1'h1;
    straps = 4'hA;
    ext_ref = 1'h0;
    result = 14'h2D3C;
    sub = 2'h1;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (2) @(posedge clk);
    t_reset;
    t_read;
    t_miss;
    t_hs;
    t_ref_off;
    tally_and_finish;
  end
endmodule
